// ===== foa_top.sv
// Carrier offset, automatic frequency correction loop and transmit rate generator.
`timescale 1ns/1ps
`include "foa_cfg.svh"

// Notes on behaviour
// - The manual offset drives the oscillator only while correction is off.
// - Manual offset and correction share one value; only one acts.
// - The 10-bit offset is a two's complement signed number.
// - One offset step is 156.25 Hz times one plus the band bit.
// - Range is +-160 kHz in high band and +-80 kHz in low band.
// - Both offset and correction act by shifting the oscillator.
// - After preamble detection the correction is held until packet end.
// - In multi-packet receive the correction clears at each packet end.
// - The correction is bounded by an unsigned pull-in limit register.
// - Gear 000 applies full error; each increment halves the feedback.
// - Each cycle measures two bit periods, updates, then settles.
// - Wait field sets cycle length; 001 gives two plus two bits.
// - Wait field zero gives no correction output.
// - Software reads the low eight bits of the present correction value.
// - Rate is word times 1 MHz over two to 16 plus 5 times prescale.
// - The rate word affects transmit only.
// - Rates from 0.477 bps to just under 1000 kbps are supported.
// - Band bit one selects high band, zero the halved low band.
module foa_top
   import foa_pkg::*;
(
   // Clock and reset
   input  wire logic               mclk_i,
   input  wire logic               nrst_i,
   // Register port
   input  wire foa_req_s           reg_req_i,
   output logic [7:0]              reg_rdata_o,
   // Radio status and measured error
   input  wire foa_radio_s         radio_i,
   // Oscillator shift and transmit bit strobe
   output logic signed [10:0]      lo_shift_o,
   output logic                    tx_bit_tick_o
);

   // ===========================================================
   // State
   // All state lives in one struct, so reset and update cannot drift apart.
   foa_state_s         s_q;
   foa_state_s         s_d;
   logic               act;
   logic               upd;
   logic [2:0]         gear;
   logic [2:0]         wait_len;
   logic signed [8:0]  efull;
   logic signed [7:0]  eavg;
   logic signed [7:0]  escl;
   logic signed [10:0] corr;
   logic signed [10:0] lim;
   logic [21:0]        sum;
   logic [9:0]         off_mag;

   // Every output comes straight from a flip-flop of the state struct.
   assign reg_rdata_o   = s_q.rdata;
   assign lo_shift_o    = s_q.lo;
   assign tx_bit_tick_o = s_q.tick;

   // ===========================================================
   // Next state
   always_comb begin
      s_d   = s_q;
      gear  = s_q.afc_cfg[`FOA_GEAR_LSB +: 3];
      wait_len = s_q.afc_cfg[`FOA_WAIT_LSB +: 3];
      act   = radio_i.rx && s_q.afc_cfg[`FOA_AFCEN_BIT];
      upd   = 1'b0;
      // Nine bits hold the sum of two samples, so the average cannot wrap.
      efull = s_q.esum + {radio_i.err[7], radio_i.err};
      eavg  = efull[8:1];
      // The shift rounds toward minus infinity, a bias of at most one step.
      escl  = eavg >>> gear;
      corr  = {s_q.off[9], s_q.off} - {{3{escl[7]}}, escl};
      lim   = {3'b000, s_q.limit};
      sum   = 22'h000000;

      // Register writes.
      // The correction register has no write entry; software cannot steer the loop.
      if (reg_req_i.wr) begin
         case (reg_req_i.addr)
            `FOA_A_LIMIT:    s_d.limit = reg_req_i.wdata;
            `FOA_A_AFC_CFG:  s_d.afc_cfg = reg_req_i.wdata;
            `FOA_A_RATE_HI:  s_d.rate_hi = reg_req_i.wdata;
            `FOA_A_RATE_LO:  s_d.rate_lo = reg_req_i.wdata;
            `FOA_A_RATE_CFG: s_d.rate_cfg = reg_req_i.wdata;
            `FOA_A_OFS_LO:   s_d.ofs_lo = reg_req_i.wdata;
            `FOA_A_OFS_HI:   s_d.ofs_hi = reg_req_i.wdata[1:0];
            `FOA_A_BAND:     s_d.band = reg_req_i.wdata;
            default: begin
            end
         endcase
      end

      // Register reads; unmapped addresses answer zero.
      // Both strobes in one cycle read the old value of the register.
      if (reg_req_i.rd) begin
         case (reg_req_i.addr)
            `FOA_A_LIMIT:    s_d.rdata = s_q.limit;
            `FOA_A_CORR:     s_d.rdata = s_q.off[7:0];
            `FOA_A_AFC_CFG:  s_d.rdata = s_q.afc_cfg;
            `FOA_A_RATE_HI:  s_d.rdata = s_q.rate_hi;
            `FOA_A_RATE_LO:  s_d.rdata = s_q.rate_lo;
            `FOA_A_RATE_CFG: s_d.rdata = s_q.rate_cfg;
            `FOA_A_OFS_LO:   s_d.rdata = s_q.ofs_lo;
            `FOA_A_OFS_HI:   s_d.rdata = {6'h00, s_q.ofs_hi};
            `FOA_A_BAND:     s_d.rdata = s_q.band;
            default:         s_d.rdata = 8'h00;
         endcase
      end

      // ========================================================
      // Shared offset value and correction loop
      if (!act) begin
         // The loop restarts cleanly so a stale measurement never leaks in.
         s_d.off  = {s_q.ofs_hi, s_q.ofs_lo};
         s_d.st   = FOA_MEAS;
         s_d.bcnt = 4'h0;
         s_d.esum = 9'h000;
      end else if (!s_q.act) begin
         // Entering the loop starts from zero; the manual value never seeds it.
         s_d.off  = 10'h000;
         s_d.st   = FOA_MEAS;
         s_d.bcnt = 4'h0;
         s_d.esum = 9'h000;
      end else if (radio_i.pkt_end) begin
         // A packet end beats a preamble or bit strobe in the same cycle.
         if (radio_i.multi) begin
            s_d.off = 10'h000;
         end
         s_d.st   = FOA_MEAS;
         s_d.bcnt = 4'h0;
         s_d.esum = 9'h000;
      end else if (radio_i.pre_det || s_q.st == FOA_FROZEN) begin
         s_d.st = FOA_FROZEN;
      end else if (radio_i.bit_tick) begin
         case (s_q.st)
            FOA_MEAS: begin
               s_d.esum = efull;
               s_d.bcnt = s_q.bcnt + 4'h1;
               if (s_q.bcnt == 4'h1) begin
                  upd      = (wait_len != 3'h0);
                  s_d.st   = FOA_SETTLE;
                  s_d.bcnt = 4'h0;
                  s_d.esum = 9'h000;
               end
            end
            FOA_SETTLE: begin
               s_d.bcnt = s_q.bcnt + 4'h1;
               // A wait field of zero leaves settling after a single strobe.
               if ((s_q.bcnt + 4'h1) >= {wait_len, 1'b0}) begin
                  s_d.st   = FOA_MEAS;
                  s_d.bcnt = 4'h0;
               end
            end
            default: s_d.st = FOA_MEAS;
         endcase
      end

      // Clamp to the pull-in limit; the limit also keeps the sum in range.
      // With the wait field at zero the loop still cycles but never moves the oscillator.
      if (upd) begin
         if (corr > lim) begin
            s_d.off = lim[9:0];
         end else if (corr < (11'sh000 - lim)) begin
            s_d.off = 10'(11'sh000 - lim);
         end else begin
            s_d.off = corr[9:0];
         end
      end
      s_d.act = act;

      // Step doubles in high band, giving +-160 kHz against +-80 kHz.
      if (s_d.band[`FOA_HIBAND_BIT]) begin
         s_d.lo = {s_d.off, 1'b0};
      end else begin
         s_d.lo = {s_d.off[9], s_d.off};
      end

      // ========================================================
      // Transmit rate generator
      // The phase keeps its low bits when the prescale flips, so the first strobe
      // after a change may come early; later strobes keep the programmed period.
      s_d.tick = 1'b0;
      if (!radio_i.tx) begin
         s_d.div = 6'h00;
         s_d.ph  = 21'h000000;
      end else if (s_q.div == 6'(`FOA_REF_DIV - 1)) begin
         s_d.div = 6'h00;
         sum     = {1'b0, s_q.ph} + {6'h00, s_q.rate_hi, s_q.rate_lo};
         if (s_q.rate_cfg[`FOA_SCALE_BIT]) begin
            s_d.tick = sum[21];
            s_d.ph   = sum[20:0];
         end else begin
            s_d.tick = sum[16];
            s_d.ph   = {5'h00, sum[15:0]};
         end
      end else begin
         s_d.div = s_q.div + 6'h01;
      end
   end

   // ===========================================================
   // Registers
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         // Fields without a register default start at zero.
         s_q          <= '0;
         s_q.rate_hi  <= `FOA_R_RATE_HI;
         s_q.rate_lo  <= `FOA_R_RATE_LO;
         s_q.rate_cfg <= `FOA_R_RATE_CFG;
         s_q.ofs_lo   <= `FOA_R_OFS_LO;
         s_q.ofs_hi   <= `FOA_R_OFS_HI;
         s_q.band     <= `FOA_R_BAND;
         s_q.afc_cfg  <= `FOA_R_AFC_CFG;
         s_q.limit    <= `FOA_R_LIMIT;
         s_q.lo       <= 11'h000;
         s_q.st       <= FOA_MEAS;
      end else begin
         s_q <= s_d;
      end
   end

   // ===========================================================
   // Checks
   assign off_mag = s_q.off[9] ? 10'(10'sh000 - s_q.off) : s_q.off;

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!nrst_i);

   // ===========================================================
   // Register port checks

   a_read_corr: assert property (
      reg_req_i.rd && reg_req_i.addr == `FOA_A_CORR |=> reg_rdata_o == 8'($past(s_q.off)))
      else $error("Correction read does not show the shared value.");

   a_rdata_hold: assert property (
      !reg_req_i.rd |=> $stable(reg_rdata_o))
      else $error("Read data changed without a read strobe.");

   // ===========================================================
   // Correction loop checks

   a_manual_when_off: assert property (
      !act |=> s_q.off == {$past(s_q.ofs_hi), $past(s_q.ofs_lo)})
      else $error("Manual offset not applied while correction is off.");

   a_entry_clear: assert property (
      act && !s_q.act |=> s_q.off == 10'h000)
      else $error("Correction did not start from zero.");

   a_freeze_hold: assert property (
      act && s_q.act && s_q.st == FOA_FROZEN && !radio_i.pkt_end |=> $stable(s_q.off))
      else $error("Correction changed while frozen.");

   a_frozen_stay: assert property (
      act && s_q.act && s_q.st == FOA_FROZEN && !radio_i.pkt_end |=> s_q.st == FOA_FROZEN)
      else $error("Loop left the frozen state before packet end.");

   a_mpk_clear: assert property (
      act && s_q.act && radio_i.pkt_end && radio_i.multi |=> s_q.off == 10'h000)
      else $error("Correction not cleared at packet end.");

   a_pull_limit: assert property (
      upd |=> off_mag <= {2'b00, $past(s_q.limit)})
      else $error("Correction exceeds the pull-in limit.");

   a_no_wait_zero: assert property (
      act && s_q.act && wait_len == 3'h0 && !radio_i.pkt_end |=> $stable(s_q.off))
      else $error("Correction output with wait field zero.");

   a_band_scale: assert property (
      ##1 s_q.lo == (s_q.band[`FOA_HIBAND_BIT] ? {s_q.off, 1'b0} : {s_q.off[9], s_q.off}))
      else $error("Oscillator shift does not match band step.");

   // ===========================================================
   // Rate generator checks

   a_tx_only: assert property (
      !radio_i.tx |=> !tx_bit_tick_o && s_q.div == 6'h00)
      else $error("Rate generator ran outside transmit.");

   a_tick_needs_tx: assert property (
      tx_bit_tick_o |-> $past(radio_i.tx))
      else $error("Transmit bit strobe without transmit mode.");

   a_tick_gap: assert property (
      tx_bit_tick_o |=> !tx_bit_tick_o [*8])
      else $error("Transmit bit strobes too close.");

   c_afc_update: cover property (upd ##1 s_q.st == FOA_SETTLE);
   c_freeze: cover property (act && radio_i.pre_det ##1 s_q.st == FOA_FROZEN);
   c_mpk: cover property (act && radio_i.pkt_end && radio_i.multi);
   c_wait_zero: cover property (act && wait_len == 3'h0 && radio_i.bit_tick);
   c_tx_tick: cover property (tx_bit_tick_o);

endmodule : foa_top

// ===== foa_cfg.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef FOA_CFG_SVH
`define FOA_CFG_SVH
// ===========================================================
// Register offsets
`define FOA_A_LIMIT    7'h2A
`define FOA_A_CORR     7'h2B
`define FOA_A_AFC_CFG  7'h1D
`define FOA_A_RATE_HI  7'h6E
`define FOA_A_RATE_LO  7'h6F
`define FOA_A_RATE_CFG 7'h70
`define FOA_A_OFS_LO   7'h73
`define FOA_A_OFS_HI   7'h74
`define FOA_A_BAND     7'h75
// ===========================================================
// Reset values
`define FOA_R_LIMIT    8'h00
`define FOA_R_AFC_CFG  8'h01
`define FOA_R_RATE_HI  8'h0A
`define FOA_R_RATE_LO  8'h3D
`define FOA_R_RATE_CFG 8'h00
`define FOA_R_OFS_LO   8'h00
`define FOA_R_OFS_HI   2'h0
`define FOA_R_BAND     8'h35
// ===========================================================
// Field positions
`define FOA_AFCEN_BIT  7
`define FOA_GEAR_LSB   4
`define FOA_WAIT_LSB   0
`define FOA_SCALE_BIT  5
`define FOA_HIBAND_BIT 5
// ===========================================================
// Timing
`define FOA_MCLK_HZ    50000000
`define FOA_REF_HZ     1000000
`define FOA_REF_DIV    (`FOA_MCLK_HZ / `FOA_REF_HZ)
`endif

// ===== foa_pkg.sv
// Types shared by the offset, correction and rate generator block.
package foa_pkg;
   typedef enum logic [1:0] {FOA_MEAS, FOA_SETTLE, FOA_FROZEN} foa_st_e;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [6:0] addr;
      logic [7:0] wdata;
   } foa_req_s;
   typedef struct packed {
      logic              rx;
      logic              tx;
      logic              multi;
      logic              pre_det;
      logic              pkt_end;
      logic              bit_tick;
      logic signed [7:0] err;
   } foa_radio_s;
   typedef struct packed {
      logic [7:0]         rate_hi;
      logic [7:0]         rate_lo;
      logic [7:0]         rate_cfg;
      logic [7:0]         ofs_lo;
      logic [1:0]         ofs_hi;
      logic [7:0]         band;
      logic [7:0]         afc_cfg;
      logic [7:0]         limit;
      logic signed [9:0]  off;
      logic signed [10:0] lo;
      logic               act;
      foa_st_e            st;
      logic [3:0]         bcnt;
      logic signed [8:0]  esum;
      logic [5:0]         div;
      logic [20:0]        ph;
      logic               tick;
      logic [7:0]         rdata;
   } foa_state_s;
endpackage : foa_pkg

// ===== foa_top_tb.sv
// Self-checking testbench for the offset, correction and rate generator block.
`timescale 1ns/1ps
module foa_top_tb;
   import foa_pkg::*;
   // =========================================================
   // Signals
   typedef struct packed {logic [6:0] a; logic [7:0] e;} foa_row_s;
   logic        mclk_i;
   logic        nrst_i;
   foa_req_s    req;
   foa_radio_s  radio;
   logic [7:0]  rdata;
   logic [10:0] lo;
   logic        tick;
   int          bad_count;
   int          tests_run;
   int          gap;
   foa_row_s    rows [10];

   foa_top DUT (
      .mclk_i        (mclk_i),
      .nrst_i        (nrst_i),
      .reg_req_i     (req),
      .reg_rdata_o   (rdata),
      .radio_i       (radio),
      .lo_shift_o    (lo),
      .tx_bit_tick_o (tick)
   );

   initial begin
      mclk_i = 1'b0;
      forever #10 mclk_i = ~mclk_i;
   end

   // =========================================================
   // Tasks
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         bad_count++;
      end
   endtask : chk

   task automatic test_done;
      if (bad_count == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done

   task automatic cyc(input int n);
      repeat (n) @(negedge mclk_i);
   endtask : cyc

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge mclk_i);
      req.wr    = 1'b1;
      req.addr  = a;
      req.wdata = d;
      @(negedge mclk_i);
      req.wr = 1'b0;
   endtask : wr

   // Read data is registered, so it is looked at one full cycle after the strobe.
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      @(negedge mclk_i);
      req.rd   = 1'b1;
      req.addr = a;
      @(negedge mclk_i);
      req.rd = 1'b0;
      @(negedge mclk_i);
      chk("reg_rdata", e, rdata);
   endtask : rd

   task automatic btk(input logic signed [7:0] e);
      @(negedge mclk_i);
      radio.bit_tick = 1'b1;
      radio.err      = e;
      @(negedge mclk_i);
      radio.bit_tick = 1'b0;
   endtask : btk

   task automatic pulse_end;
      @(negedge mclk_i);
      radio.pkt_end = 1'b1;
      @(negedge mclk_i);
      radio.pkt_end = 1'b0;
      cyc(2);
   endtask : pulse_end

   // A lost strobe must not hang the run, so every wait has a ceiling.
   task automatic wait_tick(input int lim, output int n);
      n = 0;
      do begin
         @(negedge mclk_i);
         n++;
      end while (tick !== 1'b1 && n < lim);
      if (n >= lim) begin
         $display("Error tx_bit_tick expected 1 seen 0");
         bad_count++;
         test_done();
      end
   endtask : wait_tick

   // =========================================================
   // Main sequence
   initial begin
      nrst_i    = 1'b0;
      req       = '0;
      radio     = '0;
      bad_count = 0;
      tests_run = 0;
      rows = '{'{7'h6E, 8'h0A}, '{7'h6F, 8'h3D}, '{7'h70, 8'h00}, '{7'h73, 8'h00},
               '{7'h74, 8'h00}, '{7'h75, 8'h35}, '{7'h1D, 8'h01}, '{7'h2A, 8'h00},
               '{7'h2B, 8'h00}, '{7'h7F, 8'h00}};
      cyc(12);
      nrst_i = 1'b1;
      foreach (rows[i]) rd(rows[i].a, rows[i].e);
      chk("lo_shift", 11'h000, lo);
      wr(7'h73, 8'h60);
      wr(7'h74, 8'h03);
      cyc(2);
      chk("lo_shift", 11'h6C0, lo);
      wr(7'h75, 8'h15);
      cyc(2);
      chk("lo_shift", 11'h760, lo);
      wr(7'h2B, 8'h55);
      rd(7'h2B, 8'h60);
      wr(7'h2A, 8'h10);
      wr(7'h1D, 8'h81);
      radio.rx = 1'b1;
      cyc(2);
      chk("lo_shift", 11'h000, lo);
      btk(8'sh08);
      btk(8'sh08);
      cyc(2);
      chk("lo_shift", 11'h7F8, lo);
      rd(7'h2B, 8'hF8);
      // Large errors during settling must not be measured.
      btk(8'sh64);
      btk(8'sh64);
      btk(8'sh04);
      btk(8'sh04);
      cyc(2);
      chk("lo_shift", 11'h7F4, lo);
      btk(8'sh00);
      btk(8'sh00);
      btk(8'sh64);
      btk(8'sh64);
      cyc(2);
      chk("lo_shift", 11'h7F0, lo);
      radio.pre_det = 1'b1;
      cyc(1);
      radio.pre_det = 1'b0;
      repeat (4) btk(8'sh64);
      cyc(2);
      chk("lo_shift", 11'h7F0, lo);
      radio.multi = 1'b1;
      pulse_end();
      chk("lo_shift", 11'h000, lo);
      wr(7'h1D, 8'h91);
      btk(8'sh08);
      btk(8'sh08);
      cyc(2);
      chk("lo_shift", 11'h7FC, lo);
      wr(7'h1D, 8'h90);
      pulse_end();
      repeat (4) btk(8'sh08);
      cyc(2);
      chk("lo_shift", 11'h000, lo);
      wr(7'h1D, 8'h81);
      wr(7'h6E, 8'h10);
      wr(7'h6F, 8'h00);
      radio.rx = 1'b0;
      radio.tx = 1'b1;
      cyc(2);
      chk("lo_shift", 11'h760, lo);
      wait_tick(2000, gap);
      wait_tick(2000, gap);
      chk("tick_gap", 16'h0320, 16'(gap));
      wr(7'h70, 8'h20);
      wr(7'h6E, 8'h40);
      wait_tick(16000, gap);
      wait_tick(16000, gap);
      chk("tick_gap", 16'h1900, 16'(gap));
      radio.tx = 1'b0;
      gap = 0;
      repeat (200) begin
         @(negedge mclk_i);
         gap += int'(tick);
      end
      chk("tick_count", 16'h0000, 16'(gap));
      nrst_i = 1'b0;
      cyc(2);
      nrst_i = 1'b1;
      foreach (rows[i]) rd(rows[i].a, rows[i].e);
      chk("lo_shift", 11'h000, lo);
      test_done();
   end
endmodule : foa_top_tb
